// ### rtl/tpw_pkg.sv
package tpw_pkg;
    // Widths
    localparam int unsigned DW = 16;
    localparam int unsigned DAW = 8;
    localparam int unsigned SAW = 4;
    localparam int unsigned STW = 5;

    // Device register map, one 16-bit word per index
    localparam logic [DAW-1:0] DEV_CMOR_M = 8'h00;
    localparam logic [DAW-1:0] DEV_CMOR_S = 8'h01;
    localparam logic [DAW-1:0] DEV_CMUR_M = 8'h02;
    localparam logic [DAW-1:0] DEV_CMUR_S = 8'h03;
    localparam logic [DAW-1:0] DEV_CDR_M = 8'h04;
    localparam logic [DAW-1:0] DEV_CDR_S = 8'h05;
    localparam logic [DAW-1:0] DEV_CNT_M = 8'h06;
    localparam logic [DAW-1:0] DEV_CNT_S = 8'h07;
    localparam logic [DAW-1:0] DEV_TOE = 8'h08;
    localparam logic [DAW-1:0] DEV_TOM = 8'h09;
    localparam logic [DAW-1:0] DEV_TOC = 8'h0A;
    localparam logic [DAW-1:0] DEV_TOL = 8'h0B;
    localparam logic [DAW-1:0] DEV_TDE = 8'h0C;
    localparam logic [DAW-1:0] DEV_TDL = 8'h0D;
    localparam logic [DAW-1:0] DEV_RDE = 8'h0E;
    localparam logic [DAW-1:0] DEV_RDS = 8'h0F;
    localparam logic [DAW-1:0] DEV_RDM = 8'h10;
    localparam logic [DAW-1:0] DEV_RDC = 8'h11;
    localparam logic [DAW-1:0] DEV_TS = 8'h12;
    localparam logic [DAW-1:0] DEV_TT = 8'h13;
    localparam logic [DAW-1:0] DEV_TE = 8'h14;
    localparam logic [DAW-1:0] DEV_TO = 8'h15;
    localparam logic [DAW-1:0] DEV_RSF = 8'h16;
    localparam logic [DAW-1:0] DEV_RDT = 8'h17;

    // Channel bits in the per-channel bit registers: master bit 0, slave bit 1
    localparam logic [DW-1:0] CH_NONE = 16'h0000;
    localparam logic [DW-1:0] CH_MASTER = 16'h0001;
    localparam logic [DW-1:0] CH_SLAVE = 16'h0002;
    localparam logic [DW-1:0] CH_BOTH = 16'h0003;

    // Channel mode word fields
    localparam int unsigned CMOR_CKS_LSB = 14;
    localparam int unsigned CMOR_COUNT_CLOCK_SOURCE = 12;
    localparam int unsigned CMOR_MAS = 11;
    localparam int unsigned CMOR_STS_LSB = 8;
    localparam int unsigned CMOR_COS_LSB = 6;
    localparam int unsigned CMOR_MD_LSB = 1;
    localparam int unsigned CMOR_MD0 = 0;
    localparam logic [2:0] STS_SOFT = 3'h0;
    localparam logic [2:0] STS_UDS = 3'h7;
    localparam logic [1:0] COS_UNUSED = 2'h0;
    localparam logic [3:0] MD_INTERVAL = 4'h0;
    localparam logic [3:0] MD_UPDOWN = 4'h9;

    // Software register map
    localparam logic [SAW-1:0] SW_CTRL = 4'h0;
    localparam logic [SAW-1:0] SW_CFG = 4'h1;
    localparam logic [SAW-1:0] SW_PERIOD = 4'h2;
    localparam logic [SAW-1:0] SW_DUTY = 4'h3;
    localparam logic [SAW-1:0] SW_CNT_M = 4'h4;
    localparam logic [SAW-1:0] SW_CNT_S = 4'h5;
    localparam logic [SAW-1:0] SW_RSF = 4'h6;
    localparam int unsigned CTRL_START = 0;
    localparam int unsigned CTRL_STOP = 1;
    localparam int unsigned CTRL_UPD = 2;
    localparam int unsigned CFG_CKS_LSB = 0;
    localparam int unsigned CFG_MD0 = 2;
    localparam int unsigned CFG_TOL = 3;
    localparam int unsigned CFG_RDE = 4;
    localparam int unsigned CFG_RDS = 5;
    localparam int unsigned CFG_IDLE = 6;
    localparam logic [DW-1:0] CFG_MASK = 16'h007F;
    localparam logic [DW-1:0] CFG_RST = 16'h0000;
    localparam logic [DW-1:0] PERIOD_RST = 16'h00FF;
    localparam logic [DW-1:0] DUTY_RST = 16'h0080;

    // Sequence lengths (index of the last step)
    localparam logic [STW-1:0] START_LAST = 5'h10;
    localparam logic [STW-1:0] STOP_LAST = 5'h01;
    localparam logic [STW-1:0] UPD_LAST = 5'h02;
    localparam logic [STW-1:0] POLL_LAST = 5'h03;

    // Read turnaround: device answer one cycle after the strobe, plus two sync stages
    localparam logic [2:0] READ_LAT = 3'h4;

    typedef enum logic [2:0] {S_IDLE, S_START, S_STOP, S_UPD, S_POLL} tpw_state_t;
    typedef enum logic {P_IDLE, P_WAIT} tpw_port_state_t;
endpackage : tpw_pkg

// ### rtl/tpw_acc_if.sv
`timescale 1ns/1ps
interface tpw_acc_if import tpw_pkg::*; ();
    logic req;
    logic we;
    logic [DAW-1:0] addr;
    logic [DW-1:0] wdata;
    logic done;
    logic [DW-1:0] rdata;
    modport ctrl (output req, output we, output addr, output wdata, input done, input rdata);
    modport port (input req, input we, input addr, input wdata, output done, output rdata);
endinterface : tpw_acc_if

// ### rtl/tpw_sync2.sv
`timescale 1ns/1ps
module tpw_sync2 #(
    parameter int unsigned W = 16
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule : tpw_sync2

// ### rtl/tpw_dev_port.sv
`timescale 1ns/1ps
module tpw_dev_port import tpw_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Access requests from the sequencer
    tpw_acc_if.port acc,
    // Device register pins
    output logic [DAW-1:0] dev_addr,
    output logic [DW-1:0] dev_wdata,
    output logic dev_wr,
    output logic dev_rd,
    input wire logic [DW-1:0] rdata_sync
);
    tpw_port_state_t st_q, st_d;
    logic [2:0] cnt_q, cnt_d;
    logic [DAW-1:0] addr_q, addr_d;
    logic [DW-1:0] wdata_q, wdata_d;
    logic [DW-1:0] rdata_q, rdata_d;
    logic wr_q, wr_d;
    logic rd_q, rd_d;
    logic done_q, done_d;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        wr_d = 1'b0;
        rd_d = 1'b0;
        done_d = 1'b0;
        case (st_q)
            P_IDLE: begin
                if (acc.req) begin
                    addr_d = acc.addr;
                    wdata_d = acc.wdata;
                    if (acc.we) begin
                        // Writes complete with the strobe itself
                        wr_d = 1'b1;
                        done_d = 1'b1;
                    end else begin
                        rd_d = 1'b1;
                        cnt_d = READ_LAT;
                        st_d = P_WAIT;
                    end
                end
            end
            P_WAIT: begin
                cnt_d = cnt_q - 3'h1;
                if (cnt_q == 3'h1) begin
                    // Synchronised answer stands only in this cycle
                    rdata_d = rdata_sync;
                    done_d = 1'b1;
                    st_d = P_IDLE;
                end
            end
            default: st_d = P_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_q <= P_IDLE;
            cnt_q <= 3'h0;
            addr_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            done_q <= done_d;
        end
    end

    assign dev_addr = addr_q;
    assign dev_wdata = wdata_q;
    assign dev_wr = wr_q;
    assign dev_rd = rd_q;
    assign acc.done = done_q;
    assign acc.rdata = rdata_q;

    sequence rd_strobe;
        dev_rd;
    endsequence

    read_done_a: assert property (@(posedge mclk) disable iff (!rst_b)
        rd_strobe |-> !acc.done [*4] ##1 acc.done)
        else $error("read answer not returned four cycles after strobe");

    strobe_excl_a: assert property (@(posedge mclk) disable iff (!rst_b)
        dev_wr |-> !dev_rd && acc.done && $past(acc.req))
        else $error("write strobe not paired with its completion");
endmodule : tpw_dev_port

// ### rtl/tpw_host.sv
`timescale 1ns/1ps
// Notes on behaviour
// - slave clock select equals master's
// - slave counts on operation clock
// - slave channel marked as slave
// - slave starts on master up/down trigger
// - slave mode is up/down counting
// - unused capture and edge fields zero
// - slave output synchronous mode two
// - dead time and its levels off
// - identical rewrite settings both channels
// - start both channels in one write
// - stop both channels in one write
// - configure everything before start
module tpw_host import tpw_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Software register port
    input wire logic [SAW-1:0] sw_addr,
    input wire logic [DW-1:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [DW-1:0] sw_rdata,
    // Device register pins
    output logic [DAW-1:0] dev_addr,
    output logic [DW-1:0] dev_wdata,
    output logic dev_wr,
    output logic dev_rd,
    input wire logic [DW-1:0] dev_rdata
);
    tpw_acc_if acc ();

    logic [DW-1:0] rdata_sync;

    tpw_sync2 #(.W(DW)) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .din(dev_rdata),
        .dout(rdata_sync)
    );

    tpw_dev_port u_port (
        .mclk(mclk),
        .rst_b(rst_b),
        .acc(acc.port),
        .dev_addr(dev_addr),
        .dev_wdata(dev_wdata),
        .dev_wr(dev_wr),
        .dev_rd(dev_rd),
        .rdata_sync(rdata_sync)
    );

    tpw_state_t st_q, st_d;
    logic [STW-1:0] step_q, step_d;
    logic wait_q, wait_d;
    logic running_q, running_d;
    logic [2:0] pend_q, pend_d;
    logic [DW-1:0] cfg_q, cfg_d;
    logic [DW-1:0] period_q, period_d;
    logic [DW-1:0] duty_q, duty_d;
    logic [DW-1:0] cnt_m_q, cnt_m_d;
    logic [DW-1:0] cnt_s_q, cnt_s_d;
    logic [DW-1:0] rsf_q, rsf_d;
    logic [DW-1:0] te_q, te_d;
    logic [DW-1:0] rd_data_q, rd_data_d;

    logic [1:0] cks;
    logic [DW-1:0] tol_bits;
    logic [DW-1:0] rde_bits;
    logic [DW-1:0] rds_bits;
    logic [DW-1:0] idle_bits;
    logic acc_we;
    logic [DAW-1:0] acc_addr;
    logic [DW-1:0] acc_wdata;
    logic [STW-1:0] last_step;
    logic busy;

    assign cks = cfg_q[CFG_CKS_LSB +: 2];
    assign tol_bits = cfg_q[CFG_TOL] ? CH_SLAVE : CH_NONE;
    assign rde_bits = cfg_q[CFG_RDE] ? CH_BOTH : CH_NONE;
    assign rds_bits = cfg_q[CFG_RDS] ? CH_BOTH : CH_NONE;
    assign idle_bits = cfg_q[CFG_IDLE] ? CH_BOTH : CH_NONE;
    assign busy = (st_q != S_IDLE) || (pend_q != 3'h0);

    // Device access for the current step of each sequence
    always_comb begin
        acc_we = 1'b1;
        acc_addr = DEV_CMOR_M;
        acc_wdata = CH_NONE;
        last_step = START_LAST;
        case (st_q)
            S_START: begin
                case (step_q)
                    5'h00: begin
                        acc_addr = DEV_CMOR_M;
                        acc_wdata = {cks, 1'b0, 1'b0, 1'b1, STS_SOFT, COS_UNUSED, 1'b0, MD_INTERVAL,
                                     cfg_q[CFG_MD0]};
                    end
                    5'h01: begin
                        acc_addr = DEV_CMOR_S;
                        acc_wdata = {cks, 1'b0, 1'b0, 1'b0, STS_UDS, COS_UNUSED, 1'b0, MD_UPDOWN, 1'b0};
                    end
                    5'h02: acc_addr = DEV_CMUR_M;
                    5'h03: acc_addr = DEV_CMUR_S;
                    5'h04: begin
                        acc_addr = DEV_TOE;
                        acc_wdata = CH_BOTH;
                    end
                    5'h05: begin
                        acc_addr = DEV_TOM;
                        acc_wdata = CH_SLAVE;
                    end
                    5'h06: begin
                        acc_addr = DEV_TOC;
                        acc_wdata = CH_SLAVE;
                    end
                    5'h07: begin
                        acc_addr = DEV_TOL;
                        acc_wdata = tol_bits;
                    end
                    5'h08: acc_addr = DEV_TDE;
                    5'h09: acc_addr = DEV_TDL;
                    5'h0A: begin
                        acc_addr = DEV_RDE;
                        acc_wdata = rde_bits;
                    end
                    5'h0B: begin
                        acc_addr = DEV_RDS;
                        acc_wdata = rds_bits;
                    end
                    5'h0C: acc_addr = DEV_RDM;
                    5'h0D: acc_addr = DEV_RDC;
                    5'h0E: begin
                        acc_addr = DEV_CDR_M;
                        acc_wdata = period_q;
                    end
                    5'h0F: begin
                        acc_addr = DEV_CDR_S;
                        acc_wdata = duty_q;
                    end
                    default: begin
                        acc_addr = DEV_TS;
                        acc_wdata = CH_BOTH;
                    end
                endcase
            end
            S_STOP: begin
                last_step = STOP_LAST;
                if (step_q == 5'h00) begin
                    acc_addr = DEV_TT;
                    acc_wdata = CH_BOTH;
                end else begin
                    acc_addr = DEV_TO;
                    acc_wdata = idle_bits;
                end
            end
            S_UPD: begin
                last_step = UPD_LAST;
                if (step_q == 5'h00) begin
                    acc_addr = DEV_CDR_M;
                    acc_wdata = period_q;
                end else if (step_q == 5'h01) begin
                    acc_addr = DEV_CDR_S;
                    acc_wdata = duty_q;
                end else begin
                    // Request the joint transfer only when rewriting is enabled
                    acc_addr = DEV_RDT;
                    acc_wdata = cfg_q[CFG_RDE] ? CH_MASTER : CH_NONE;
                end
            end
            S_POLL: begin
                last_step = POLL_LAST;
                acc_we = 1'b0;
                if (step_q == 5'h00) begin
                    acc_addr = DEV_CNT_M;
                end else if (step_q == 5'h01) begin
                    acc_addr = DEV_CNT_S;
                end else if (step_q == 5'h02) begin
                    acc_addr = DEV_RSF;
                end else begin
                    acc_addr = DEV_TE;
                end
            end
            default: acc_we = 1'b0;
        endcase
    end

    assign acc.req = (st_q != S_IDLE) && !wait_q;
    assign acc.we = acc_we;
    assign acc.addr = acc_addr;
    assign acc.wdata = acc_wdata;

    // Sequencer and software registers
    always_comb begin
        st_d = st_q;
        step_d = step_q;
        wait_d = wait_q;
        running_d = running_q;
        pend_d = pend_q;
        cfg_d = cfg_q;
        period_d = period_q;
        duty_d = duty_q;
        cnt_m_d = cnt_m_q;
        cnt_s_d = cnt_s_q;
        rsf_d = rsf_q;
        te_d = te_q;
        rd_data_d = '0;
        case (st_q)
            S_IDLE: begin
                step_d = '0;
                wait_d = 1'b0;
                // Stop outranks start; a start while running is dropped
                if (pend_q[CTRL_STOP]) begin
                    pend_d[CTRL_STOP] = 1'b0;
                    pend_d[CTRL_START] = 1'b0;
                    st_d = S_STOP;
                end else if (pend_q[CTRL_START]) begin
                    pend_d[CTRL_START] = 1'b0;
                    if (!running_q) begin
                        st_d = S_START;
                    end
                end else if (pend_q[CTRL_UPD]) begin
                    pend_d[CTRL_UPD] = 1'b0;
                    st_d = S_UPD;
                end else if (running_q) begin
                    st_d = S_POLL;
                end
            end
            default: begin
                if (acc.req) begin
                    wait_d = 1'b1;
                end
                if (acc.done) begin
                    wait_d = 1'b0;
                    if (st_q == S_POLL) begin
                        if (step_q == 5'h00) begin
                            cnt_m_d = acc.rdata;
                        end else if (step_q == 5'h01) begin
                            cnt_s_d = acc.rdata;
                        end else if (step_q == 5'h02) begin
                            rsf_d = acc.rdata;
                        end else begin
                            te_d = acc.rdata;
                        end
                    end
                    if (step_q == last_step) begin
                        if (st_q == S_START) begin
                            running_d = 1'b1;
                        end else if (st_q == S_STOP) begin
                            running_d = 1'b0;
                        end
                        st_d = S_IDLE;
                    end else begin
                        step_d = step_q + 5'h01;
                    end
                end
            end
        endcase
        // New commands win over the clear above
        if (sw_wr) begin
            if (sw_addr == SW_CTRL) begin
                pend_d = pend_d | sw_wdata[2:0];
            end else if (sw_addr == SW_CFG) begin
                cfg_d = sw_wdata & CFG_MASK;
            end else if (sw_addr == SW_PERIOD) begin
                period_d = sw_wdata;
            end else if (sw_addr == SW_DUTY) begin
                duty_d = sw_wdata;
            end
        end
        if (sw_rd) begin
            if (sw_addr == SW_CTRL) begin
                rd_data_d = {13'h0000, |(te_q & CH_BOTH), running_q, busy};
            end else if (sw_addr == SW_CFG) begin
                rd_data_d = cfg_q;
            end else if (sw_addr == SW_PERIOD) begin
                rd_data_d = period_q;
            end else if (sw_addr == SW_DUTY) begin
                rd_data_d = duty_q;
            end else if (sw_addr == SW_CNT_M) begin
                rd_data_d = cnt_m_q;
            end else if (sw_addr == SW_CNT_S) begin
                rd_data_d = cnt_s_q;
            end else if (sw_addr == SW_RSF) begin
                rd_data_d = rsf_q;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_q <= S_IDLE;
            step_q <= '0;
            wait_q <= 1'b0;
            running_q <= 1'b0;
            pend_q <= 3'h0;
            cfg_q <= CFG_RST;
            period_q <= PERIOD_RST;
            duty_q <= DUTY_RST;
            cnt_m_q <= '0;
            cnt_s_q <= '0;
            rsf_q <= '0;
            te_q <= '0;
            rd_data_q <= '0;
        end else begin
            st_q <= st_d;
            step_q <= step_d;
            wait_q <= wait_d;
            running_q <= running_d;
            pend_q <= pend_d;
            cfg_q <= cfg_d;
            period_q <= period_d;
            duty_q <= duty_d;
            cnt_m_q <= cnt_m_d;
            cnt_s_q <= cnt_s_d;
            rsf_q <= rsf_d;
            te_q <= te_d;
            rd_data_q <= rd_data_d;
        end
    end

    assign sw_rdata = rd_data_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence slave_mode_wr;
        acc.req && acc.we && acc.addr == DEV_CMOR_S;
    endsequence

    sequence trig_wr(logic [DAW-1:0] a);
        acc.req && acc.we && acc.addr == a;
    endsequence

    cks_match_a: assert property (slave_mode_wr |-> acc.wdata[CMOR_CKS_LSB +: 2] == cfg_q[CFG_CKS_LSB +: 2])
        else $error("slave clock select differs from master");
    slave_src_a: assert property (slave_mode_wr |-> !acc.wdata[CMOR_COUNT_CLOCK_SOURCE] && !acc.wdata[CMOR_MAS])
        else $error("slave clock source or designation bit set");
    slave_trig_a: assert property (slave_mode_wr |-> acc.wdata[CMOR_STS_LSB +: 3] == STS_UDS)
        else $error("slave start trigger select not up/down trigger");
    slave_mode_a: assert property (slave_mode_wr |-> acc.wdata[CMOR_MD_LSB +: 4] == MD_UPDOWN
        && acc.wdata[CMOR_COS_LSB +: 2] == COS_UNUSED && !acc.wdata[CMOR_MD0])
        else $error("slave mode word wrong");
    out_mode_a: assert property (trig_wr(DEV_TOC) |-> acc.wdata == CH_SLAVE && $past(acc.addr, 2) == DEV_TOM)
        else $error("slave output configuration not set after synchronous mode");
    dead_off_a: assert property (trig_wr(DEV_TDE) |-> acc.wdata == CH_NONE)
        else $error("dead time enabled");
    rewrite_same_a: assert property (trig_wr(DEV_RDE) |-> acc.wdata == CH_NONE || acc.wdata == CH_BOTH)
        else $error("rewrite enable differs between channels");
    start_pair_a: assert property (trig_wr(DEV_TS) |-> acc.wdata == CH_BOTH && !running_q
        ##1 acc.done ##1 running_q)
        else $error("start not issued as one paired write");
    stop_pair_a: assert property (trig_wr(DEV_TT) |-> acc.wdata == CH_BOTH ##1 acc.done [*1] ##[1:4] acc.req
        && acc.addr == DEV_TO)
        else $error("stop not followed by idle level write");
    cfg_first_a: assert property (trig_wr(DEV_TS) |-> st_q == S_START && step_q == START_LAST)
        else $error("start issued before configuration finished");
endmodule : tpw_host

// ### sim/tpw_dev_model.sv
`timescale 1ns/1ps
module tpw_dev_model import tpw_pkg::*; (
    // Register pins
    input wire logic mclk,
    input wire logic [DAW-1:0] dev_addr,
    input wire logic [DW-1:0] dev_wdata,
    input wire logic dev_wr,
    input wire logic dev_rd,
    output logic [DW-1:0] dev_rdata
);
    logic [DW-1:0] mem [0:31] = '{default: 16'h0000};
    logic rd_q = 1'b0;
    logic up_q = 1'b0;
    logic [DW-1:0] val_q = 16'h0000;
    always @(posedge mclk) begin
        rd_q <= dev_rd;
        if (dev_rd) val_q <= mem[dev_addr[4:0]];
        // start sets status and loads counters; stop clears status
        if (dev_wr && dev_addr == DEV_TS) begin
            mem[20] <= mem[20] | dev_wdata;
            mem[6] <= mem[4];
            mem[7] <= mem[5];
            up_q <= 1'b0;
        end else if (dev_wr && dev_addr == DEV_TT) begin
            mem[20] <= mem[20] & ~dev_wdata;
        end else if (dev_wr) begin
            mem[dev_addr[4:0]] <= dev_wdata;
        end
        // master reloads at zero; slave turns up or reloads down
        if (mem[20][0] && mem[6] == 16'h0000) begin
            mem[6] <= mem[4];
            mem[7] <= up_q ? mem[5] : mem[7] + 16'h0001;
            up_q <= !up_q;
        end else if (mem[20][0]) begin
            mem[6] <= mem[6] - 16'h0001;
            mem[7] <= up_q ? mem[7] + 16'h0001 : mem[7] - 16'h0001;
        end
    end
    // Bus not answering shows inverse of the last word
    assign dev_rdata = rd_q ? val_q : ~val_q;
endmodule : tpw_dev_model

// ### sim/tpw_host_tb.sv
`timescale 1ns/1ps
module tpw_host_tb import tpw_pkg::*;;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [SAW-1:0] sw_addr = 4'h0;
    logic [DW-1:0] sw_wdata = 16'h0000;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [DW-1:0] sw_rdata, dev_wdata, dev_rdata;
    logic [DAW-1:0] dev_addr;
    logic dev_wr, dev_rd;
    int n_errors = 0;
    int samples_checked = 0;
    always #50 mclk = ~mclk;
    tpw_host dut (.mclk(mclk), .rst_b(rst_b), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
        .sw_rd(sw_rd), .sw_rdata(sw_rdata), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
        .dev_rd(dev_rd), .dev_rdata(dev_rdata));
    tpw_dev_model dev (.mclk(mclk), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
        .dev_rd(dev_rd), .dev_rdata(dev_rdata));
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [SAW-1:0] a, input logic [DW-1:0] d);
        @(posedge mclk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge mclk);
        sw_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [SAW-1:0] a, input logic [DW-1:0] exp);
        @(posedge mclk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge mclk);
        sw_rd <= 1'b0;
        #1 chk(sw_rdata, exp);
    endtask : rd
    task automatic t_regs;
        rd(SW_CFG, CFG_RST);
        rd(SW_PERIOD, PERIOD_RST);
        rd(SW_DUTY, DUTY_RST);
        rd(4'hF, 16'h0000);
        wr(SW_CFG, 16'hFFFF);
        rd(SW_CFG, CFG_MASK);
        wr(SW_CFG, 16'h005F);
        wr(SW_PERIOD, 16'h0005);
        wr(SW_DUTY, 16'h0006);
    endtask : t_regs
    task automatic t_start;
        wr(SW_CTRL, 16'h0001);
        for (int i = 0; i < 200 && !(dev_wr === 1'b1 && dev_addr === DEV_TS); i++) @(posedge mclk);
        repeat (2) @(posedge mclk);
        chk(dev.mem[1], 16'hC712);
        chk(dev.mem[0], 16'hC801);
        chk(dev.mem[2] | dev.mem[3], 16'h0000);
        chk({12'h000, dev.mem[8][1], dev.mem[9][1], dev.mem[10][1], dev.mem[11][1]}, 16'h000F);
        chk(dev.mem[12] | dev.mem[13], 16'h0000);
        chk(dev.mem[14], 16'h0003);
        chk(dev.mem[15] | dev.mem[16] | dev.mem[17], 16'h0000);
        chk(dev.mem[4], 16'h0005);
        chk(dev.mem[5], 16'h0006);
        chk(dev.mem[20], 16'h0003);
    endtask : t_start
    task automatic t_poll;
        logic [DW-1:0] exp_m;
        logic [DW-1:0] exp_s;
        logic seen;
        exp_m = 16'h0000;
        exp_s = 16'h0000;
        seen = 1'b0;
        // Take the counter value at the very edge the device latches it
        for (int i = 0; i < 100; i++) begin
            @(posedge mclk);
            if (dev_rd === 1'b1 && dev_addr === DEV_CNT_M) begin
                exp_m = dev.mem[6];
                seen = 1'b1;
            end
            if (dev_rd === 1'b1 && dev_addr === DEV_CNT_S && seen) begin
                exp_s = dev.mem[7];
                break;
            end
        end
        repeat (6) @(posedge mclk);
        rd(SW_CNT_M, exp_m);
        rd(SW_CNT_S, exp_s);
    endtask : t_poll
    task automatic t_update;
        wr(SW_DUTY, 16'h0002);
        wr(SW_CTRL, 16'h0004);
        repeat (60) @(posedge mclk);
        chk(dev.mem[5], 16'h0002);
        chk(dev.mem[23], 16'h0001);
    endtask : t_update
    task automatic t_stop;
        wr(SW_CTRL, 16'h0002);
        repeat (40) @(posedge mclk);
        chk(dev.mem[20], 16'h0000);
        chk(dev.mem[21], 16'h0003);
        rd(SW_CTRL, 16'h0004);
    endtask : t_stop
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (3000) @(posedge mclk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs();
        t_start();
        t_poll();
        t_update();
        t_stop();
        tally_and_finish();
    end
endmodule : tpw_host_tb
